// File: logic/pbhs_pkg.sv
package pbhs_pkg;
    // Status bit positions; power-on status bits 8,9 read 0,1 once calibration is done
    localparam int unsigned WR_CAL_DONE_BIT  = 8;
    localparam int unsigned RD_CAL_DONE_BIT  = 9;
    localparam int unsigned RD_CAL_ACTIVE_BIT = 8;
    localparam int unsigned STAT_W           = 16;
    localparam int unsigned ADDR_W           = 40;
    localparam int unsigned ERR_W            = 8;
    // Fixed vectors
    localparam logic [ADDR_W-1:0] FIXED_VECTOR  = 40'h00_0000_0100;
    localparam logic [ADDR_W-1:0] ADDR_ZERO     = 40'h00_0000_0000;
    localparam logic [63:0]       BOOT_CFG_RST  = 64'h0000_0000_0000_0000;
    localparam int unsigned       BCFG_DIS_VEC_BIT = 0;
    // Values after reset
    localparam logic [STAT_W-1:0] STAT_RST      = 16'h0000;
    localparam logic [ERR_W-1:0]  ERR_RST       = 8'h00;
    // Sequencer states
    typedef enum logic [2:0] {
        PBHS_WAIT_CAL = 3'b000,
        PBHS_CAL_SET  = 3'b001,
        PBHS_RELEASE  = 3'b010,
        PBHS_RUN      = 3'b011
    } pbhs_state_type;
endpackage : pbhs_pkg

// File: logic/pbhs_vector_sel.sv
`timescale 1ns/1ps
`default_nettype none
// Reset vector choice for one thread
module pbhs_vector_sel
    import pbhs_pkg::*;
(
    input  wire logic              thread_one,
    input  wire logic              dis_vec,
    input  wire logic [ADDR_W-1:0] ring_reset_vector_field,
    output logic      [ADDR_W-1:0] vector
);
    // Thread 1 fixed, thread 0 fixed when ring vector disabled
    assign vector = (thread_one || dis_vec) ? FIXED_VECTOR : ring_reset_vector_field;
endmodule : pbhs_vector_sel
`default_nettype wire

// File: logic/pbhs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module pbhs_sequencer
    import pbhs_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic [STAT_W-1:0] wr_serial_status,
    input  wire logic [ADDR_W-1:0] ring_reset_vector_field,
    input  wire logic              cfg_wr_t0,
    input  wire logic              cfg_wr_t1,
    input  wire logic [63:0]       cfg_wdata_t0,
    input  wire logic [63:0]       cfg_wdata_t1,
    input  wire logic              thread_start,
    input  wire logic              thread_sel,
    input  wire logic [ERR_W-1:0]  err_event,
    input  wire logic [ERR_W-1:0]  err_clear,
    output logic      [STAT_W-1:0] rd_por_status,
    output logic      [ERR_W-1:0]  rd_serial_status,
    output logic                   core_reset_n,
    output logic                   sreset_pulse,
    output logic                   hypervisor_state_bit,
    output logic                   sixty_four_bit_mode_bit,
    output logic                   start_valid,
    output logic                   start_thread,
    output logic      [ADDR_W-1:0] start_vector,
    output logic      [63:0]       boot_config_reg,
    output logic                   attention
);
    pbhs_state_type    state_q;
    pbhs_state_type    state_d;
    logic [STAT_W-1:0] stat_q;
    logic [ERR_W-1:0]  err_q;
    logic [63:0]       bcfg_q;
    logic              hv_q;
    logic              sf_q;
    logic              sv_q;
    logic              st_q;
    logic [ADDR_W-1:0] vec_q;
    logic              srst_q;
    logic [ADDR_W-1:0] vec_sel;
    logic              sel_thread;
    logic              start_now;
    logic              cal_done;
    logic              por_done;
    logic              in_wait;

    // Decode of controller indication and start request
    assign cal_done   = wr_serial_status[WR_CAL_DONE_BIT];
    assign por_done   = (state_q == PBHS_RUN);
    assign in_wait    = (state_q == PBHS_WAIT_CAL);
    assign sel_thread = (state_q == PBHS_RELEASE) ? 1'b0 : thread_sel;
    assign start_now  = (state_q == PBHS_RELEASE) || (por_done && thread_start);

    // Next state of the power-on sequence
    always_comb begin
        case (state_q)
            PBHS_WAIT_CAL: state_d = cal_done ? PBHS_CAL_SET : PBHS_WAIT_CAL;
            PBHS_CAL_SET:  state_d = PBHS_RELEASE;
            PBHS_RELEASE:  state_d = PBHS_RUN;
            PBHS_RUN:      state_d = PBHS_RUN;
            default:       state_d = PBHS_WAIT_CAL;
        endcase
    end

    pbhs_vector_sel u_vec (
        .thread_one              (sel_thread),
        .dis_vec                 (bcfg_q[BCFG_DIS_VEC_BIT]),
        .ring_reset_vector_field (ring_reset_vector_field),
        .vector                  (vec_sel)
    );

    // State and power-on status field
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q <= PBHS_WAIT_CAL;
            stat_q  <= STAT_RST;
        end else begin
            state_q <= state_d;
            if (in_wait && !cal_done) begin
                stat_q[RD_CAL_ACTIVE_BIT] <= 1'b1;
                stat_q[RD_CAL_DONE_BIT]   <= 1'b0;
            end else if (in_wait) begin
                stat_q[RD_CAL_DONE_BIT]   <= 1'b1;
                stat_q[RD_CAL_ACTIVE_BIT] <= 1'b0;
            end
        end
    end

    // Single shared boot config; thread 0 write wins on collision
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bcfg_q <= BOOT_CFG_RST;
        end else if (cfg_wr_t0) begin
            bcfg_q <= cfg_wdata_t0;
        end else if (cfg_wr_t1) begin
            bcfg_q <= cfg_wdata_t1;
        end
    end

    // Thread start with system reset interrupt
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hv_q   <= 1'b0;
            sf_q   <= 1'b0;
            sv_q   <= 1'b0;
            st_q   <= 1'b0;
            srst_q <= 1'b0;
            vec_q  <= ADDR_ZERO;
        end else begin
            sv_q   <= start_now;
            srst_q <= start_now;
            if (start_now) begin
                st_q  <= sel_thread;
                vec_q <= vec_sel;
                hv_q  <= 1'b1;
                sf_q  <= 1'b1;
            end
        end
    end

    // Error flags; set wins over clear; attention only after power-on reset
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            err_q <= ERR_RST;
        end else begin
            err_q <= (err_q & ~err_clear) | (por_done ? err_event : ERR_RST);
        end
    end

    // Outputs from registers and state decode
    assign rd_por_status           = stat_q;
    assign rd_serial_status        = err_q;
    assign core_reset_n            = (state_q == PBHS_RELEASE) || por_done;
    assign sreset_pulse            = srst_q;
    assign hypervisor_state_bit    = hv_q;
    assign sixty_four_bit_mode_bit = sf_q;
    assign start_valid             = sv_q;
    assign start_thread            = st_q;
    assign start_vector            = vec_q;
    assign boot_config_reg         = bcfg_q;
    assign attention               = por_done && (err_q != ERR_RST);

    // Power-on sequence: status field, core hold and release
    cal_status_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        in_wait && cal_done |=> {rd_por_status[8], rd_por_status[9]} == 2'b01)
        else $error("status not done after calibration");
    stat_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) && $past(rd_por_status[RD_CAL_DONE_BIT])
        |-> rd_por_status[RD_CAL_DONE_BIT] && !rd_por_status[RD_CAL_ACTIVE_BIT])
        else $error("done status lost");
    cal_active_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(in_wait && !cal_done && rst_n)
        |-> rd_por_status[RD_CAL_ACTIVE_BIT] && !rd_por_status[RD_CAL_DONE_BIT])
        else $error("calibration not shown active");
    hold_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !rd_por_status[RD_CAL_DONE_BIT] |-> !core_reset_n && !start_valid)
        else $error("core released early");
    no_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !core_reset_n |=> !start_valid)
        else $error("start while core held");
    release_core_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        in_wait && cal_done |=> ##1 core_reset_n)
        else $error("core not released");
    release_after_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(core_reset_n) |-> $past(rd_por_status[RD_CAL_DONE_BIT]))
        else $error("core released before status");

    // Thread start: mode bits and vectors
    first_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(core_reset_n) |=> start_valid && !start_thread && sreset_pulse)
        else $error("thread 0 not started");
    hv_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        start_valid |-> hypervisor_state_bit && sixty_four_bit_mode_bit)
        else $error("mode bits not set");
    mode_sticky_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) && $past(hypervisor_state_bit) |-> hypervisor_state_bit && sixty_four_bit_mode_bit)
        else $error("mode bits dropped");
    t1_vector_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        start_valid && start_thread |-> start_vector == FIXED_VECTOR)
        else $error("thread 1 vector wrong");
    t0_disable_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        start_now && !sel_thread && bcfg_q[BCFG_DIS_VEC_BIT] |=> start_vector == FIXED_VECTOR)
        else $error("disabled vector ignored");
    t0_ring_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        start_now && !sel_thread && !bcfg_q[BCFG_DIS_VEC_BIT]
        |=> start_vector == $past(ring_reset_vector_field))
        else $error("ring vector not used");
    held_vec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !start_valid |-> $stable(start_vector) && $stable(start_thread))
        else $error("start vector changed without start");

    // Shared boot config and error reporting
    shared_cfg_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cfg_wr_t1 && !cfg_wr_t0 |=> boot_config_reg == $past(cfg_wdata_t1))
        else $error("thread 1 write lost");
    t0_wins_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cfg_wr_t0 |=> boot_config_reg == $past(cfg_wdata_t0))
        else $error("thread 0 write lost");
    attn_por_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(attention) |-> $past(err_event) != ERR_RST && $past(core_reset_n))
        else $error("attention without error");
    no_early_err_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !core_reset_n |-> rd_serial_status == ERR_RST)
        else $error("error flag before release");
    attn_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        core_reset_n && rd_serial_status != ERR_RST |-> attention)
        else $error("error flag without attention");

    // Main scenarios
    cal_seen_c: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(core_reset_n));
    t1_start_c: cover property (@(posedge clk_sys) disable iff (!rst_n) start_valid && start_thread);
    t0_fixed_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
        start_valid && !start_thread && start_vector == FIXED_VECTOR);
    cfg_both_c: cover property (@(posedge clk_sys) disable iff (!rst_n) cfg_wr_t0 && cfg_wr_t1);
    attn_c: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(attention));
endmodule : pbhs_sequencer
`default_nettype wire

// File: testbench/pbhs_sys_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// System controller on the far side: reports calibration done, then reads the error cause
module pbhs_sys_ctrl_model
    import pbhs_pkg::*;
#(
    parameter int CAL_DLY = 8
)(
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              attention,
    input  wire logic [ERR_W-1:0]  rd_serial_status,
    output logic      [STAT_W-1:0] wr_serial_status,
    output logic      [ERR_W-1:0]  cause
);
    int   cnt;
    logic att_q;
    // Calibration done is reported CAL_DLY+1 cycles after reset; a rising attention makes us fetch the cause
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt              <= 0;
            wr_serial_status <= STAT_RST;
            att_q            <= 1'b0;
            cause            <= ERR_RST;
        end else begin
            att_q <= attention;
            if (cnt < CAL_DLY) cnt <= cnt + 1;
            else wr_serial_status[WR_CAL_DONE_BIT] <= 1'b1;
            if (attention && !att_q) cause <= rd_serial_status;
        end
    end
endmodule : pbhs_sys_ctrl_model
`default_nettype wire

// File: testbench/pbhs_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Bench for the power-on hand-off sequencer
module pbhs_sequencer_tb
    import pbhs_pkg::*;
;
    localparam logic [ADDR_W-1:0] RING_VEC = 40'h12_3456_7800;
    logic clk_sys, rst_n, cfg_wr_t0, cfg_wr_t1, thread_start, thread_sel;
    logic [63:0] cfg_wdata_t0, cfg_wdata_t1, boot_config_reg;
    logic [ERR_W-1:0] err_event, err_clear, rd_serial_status, cause;
    logic [STAT_W-1:0] wr_serial_status, rd_por_status;
    logic core_reset_n, sreset_pulse, hv, sf, start_valid, start_thread, attention;
    logic [ADDR_W-1:0] start_vector;
    int n_mismatch = 0;
    int n_checks = 0;
    int i;
    pbhs_sequencer i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .wr_serial_status(wr_serial_status),
        .ring_reset_vector_field(RING_VEC), .cfg_wr_t0(cfg_wr_t0), .cfg_wr_t1(cfg_wr_t1),
        .cfg_wdata_t0(cfg_wdata_t0), .cfg_wdata_t1(cfg_wdata_t1), .thread_start(thread_start),
        .thread_sel(thread_sel), .err_event(err_event), .err_clear(err_clear),
        .rd_por_status(rd_por_status), .rd_serial_status(rd_serial_status),
        .core_reset_n(core_reset_n), .sreset_pulse(sreset_pulse), .hypervisor_state_bit(hv),
        .sixty_four_bit_mode_bit(sf), .start_valid(start_valid), .start_thread(start_thread),
        .start_vector(start_vector), .boot_config_reg(boot_config_reg), .attention(attention));
    pbhs_sys_ctrl_model i_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .attention(attention),
        .rd_serial_status(rd_serial_status), .wr_serial_status(wr_serial_status), .cause(cause));
    // Clock at 4 ns
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic step;
        @(posedge clk_sys);
        #1;
    endtask : step
    task automatic chk(input string what, input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One-cycle start request, then look at the pulse it produces
    task automatic start_thr(input logic sel, input logic [ADDR_W-1:0] exp);
        thread_start = 1'b1;
        thread_sel   = sel;
        step();
        thread_start = 1'b0;
        chk("start", 64'({start_valid, sreset_pulse, start_thread}), 64'({2'b11, sel}));
        chk("start_vector", 64'(start_vector), 64'(exp));
        step();
    endtask : start_thr
    // Boot config write from either or both threads
    task automatic cfg_w(input logic w0, input logic w1, input logic [63:0] d0, input logic [63:0] d1);
        cfg_wr_t0    = w0;
        cfg_wr_t1    = w1;
        cfg_wdata_t0 = d0;
        cfg_wdata_t1 = d1;
        step();
        cfg_wr_t0 = 1'b0;
        cfg_wr_t1 = 1'b0;
    endtask : cfg_w
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run
    // Watchdog well beyond the few dozen cycles the tests need
    initial begin
        repeat (2000) @(posedge clk_sys);
        n_mismatch++;
        $display("watchdog expired");
        complete_run();
    end
    // Test sequence
    initial begin
        {rst_n, cfg_wr_t0, cfg_wr_t1, thread_start, thread_sel} = '0;
        {cfg_wdata_t0, cfg_wdata_t1, err_event, err_clear} = '0;
        repeat (2) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        step();
        chk("por_status early", 64'(rd_por_status), 64'(16'h0100));
        thread_start = 1'b1;
        err_event    = 8'h01;
        step();
        thread_start = 1'b0;
        err_event    = 8'h00;
        chk("core_reset_n held", 64'({core_reset_n, start_valid}), 64'd0);
        step();
        chk("attention early", 64'(attention), 64'd0);
        $display("test hold done");
        i = 0;
        while (rd_por_status[RD_CAL_DONE_BIT] !== 1'b1 && i < 50) begin
            step();
            i++;
        end
        chk("por_status done", 64'({rd_por_status, core_reset_n}), 64'({16'h0200, 1'b0}));
        step();
        chk("core_reset_n", 64'(core_reset_n), 64'd1);
        step();
        chk("boot start", 64'({start_valid, sreset_pulse, start_thread}), 64'(3'b110));
        chk("boot vector", 64'(start_vector), 64'(RING_VEC));
        chk("hv sf", 64'({hv, sf}), 64'(2'b11));
        $display("test release done");
        cfg_w(1'b0, 1'b1, 64'h0, 64'h1);
        chk("boot_config_reg", boot_config_reg, 64'h1);
        start_thr(1'b0, FIXED_VECTOR);
        start_thr(1'b1, FIXED_VECTOR);
        cfg_w(1'b1, 1'b1, 64'h0, 64'h1);
        chk("boot_config_reg both", boot_config_reg, BOOT_CFG_RST);
        start_thr(1'b0, RING_VEC);
        start_thr(1'b1, FIXED_VECTOR);
        $display("test vectors done");
        err_event = 8'h24;
        step();
        err_event = 8'h00;
        chk("error flags", 64'({attention, rd_serial_status}), 64'({1'b1, 8'h24}));
        step();
        chk("cause read", 64'(cause), 64'(8'h24));
        err_clear = 8'h24;
        step();
        err_clear = 8'h00;
        chk("cleared", 64'({attention, rd_serial_status}), 64'd0);
        $display("test errors done");
        complete_run();
    end
endmodule : pbhs_sequencer_tb
`default_nettype wire
